// [logic/dip_defines.vh]
// constants for the dual issue pairing logic
`ifndef DIP_DEFINES_VH
`define DIP_DEFINES_VH
// instruction class codes produced by the classifier
`define DIP_CLS_W 5
`define DIP_C_OTHER 5'h00
`define DIP_C_NOP 5'h01
`define DIP_C_MOV 5'h02
`define DIP_C_NOT 5'h03
`define DIP_C_SAT 5'h04
`define DIP_C_ARITH 5'h05
`define DIP_C_SUBR 5'h06
`define DIP_C_CMP 5'h07
`define DIP_C_TST 5'h08
`define DIP_C_LOGIC 5'h09
`define DIP_C_SHIFT 5'h0A
`define DIP_C_MULH 5'h0B
`define DIP_C_EXT 5'h0C
`define DIP_C_SLD 5'h0D
`define DIP_C_SST 5'h0E
`define DIP_C_BR 5'h0F
`define DIP_C_BCC 5'h10
`define DIP_C_SLD_EP 5'h11
// format codes
`define DIP_FMT_W 2
`define DIP_F_I 2'h0
`define DIP_F_II 2'h1
`define DIP_F_IV 2'h2
`define DIP_F_OTHER 2'h3
// register numbers
`define DIP_REG_W 5
`define DIP_REG_ZERO 5'h00
`define DIP_REG_EP 5'h1E
// issue kinds
`define DIP_ISS_W 2
`define DIP_ISS_NONE 2'h0
`define DIP_ISS_SINGLE 2'h1
`define DIP_ISS_FUSED 2'h2
`define DIP_ISS_PAIR 2'h3
`endif

// [logic/dip_first_class.v]
// decides which class groups a leading instruction may join
`timescale 1ns/1ps
`include "dip_defines.vh"
module dip_first_class (
    input wire [`DIP_CLS_W-1:0] cls,
    input wire [`DIP_FMT_W-1:0] fmt,
    output reg ok_br,
    output reg ok_bcc,
    output reg ok_sld,
    output reg ok_fuse_op,
    output reg may_set_flags
);
    always @* begin
        ok_br = 1'b0;
        ok_bcc = 1'b0;
        ok_sld = 1'b0;
        ok_fuse_op = 1'b0;
        may_set_flags = 1'b0;
        case (cls)
            `DIP_C_NOP: begin
                ok_br = (fmt == `DIP_F_I);
                ok_bcc = (fmt == `DIP_F_I);
                ok_sld = (fmt == `DIP_F_I);
            end
            `DIP_C_MOV: begin
                ok_br = (fmt == `DIP_F_I) || (fmt == `DIP_F_II);
                ok_bcc = ok_br;
                ok_sld = ok_br;
            end
            `DIP_C_NOT, `DIP_C_TST, `DIP_C_LOGIC, `DIP_C_SUBR: begin
                ok_br = (fmt == `DIP_F_I);
                ok_sld = ok_br;
                ok_fuse_op = ok_br && (cls != `DIP_C_NOT) && (cls != `DIP_C_TST);
                may_set_flags = 1'b1;
            end
            `DIP_C_SAT, `DIP_C_ARITH, `DIP_C_CMP: begin
                ok_br = (fmt == `DIP_F_I) || (fmt == `DIP_F_II);
                ok_sld = ok_br;
                // only the register add and saturating add fuse; the immediate forms and compare stay separate
                ok_fuse_op = (cls != `DIP_C_CMP) && (fmt == `DIP_F_I);
                may_set_flags = 1'b1;
            end
            `DIP_C_SHIFT: begin
                ok_br = (fmt == `DIP_F_II);
                ok_sld = ok_br;
                ok_fuse_op = ok_br;
                may_set_flags = 1'b1;
            end
            `DIP_C_MULH: begin
                ok_br = (fmt == `DIP_F_I) || (fmt == `DIP_F_II);
                ok_bcc = ok_br;
                ok_sld = ok_br;
                ok_fuse_op = ok_br;
            end
            `DIP_C_EXT: begin
                ok_bcc = (fmt == `DIP_F_I);
            end
            `DIP_C_SLD, `DIP_C_SST, `DIP_C_SLD_EP: begin
                ok_br = (fmt == `DIP_F_IV) || ((cls != `DIP_C_SST) && (fmt == `DIP_F_I));
                ok_bcc = ok_br;
            end
            default: begin
                may_set_flags = (cls == `DIP_C_OTHER);
            end
        endcase
    end
endmodule

// [logic/dip_hazard_track.v]
// tracks element pointer writes and load buffers awaiting writeback
`timescale 1ns/1ps
`include "dip_defines.vh"
module dip_hazard_track #(
    parameter EP_WB_DEPTH = 3
) (
    input wire clk,
    input wire rst,
    input wire issue_ep_write,
    input wire load_alloc,
    input wire load_wb_done,
    output reg ep_pending,
    output reg load_bufs_full
);
    reg [EP_WB_DEPTH-1:0] ep_pipe;
    reg [1:0] busy;
    reg [1:0] next_busy;
    always @* begin
        next_busy = busy;
        if (load_alloc && !load_wb_done && busy != 2'h2) begin
            next_busy = busy + 2'h1;
        end else if (load_wb_done && !load_alloc && busy != 2'h0) begin
            next_busy = busy - 2'h1;
        end
    end
    always @(posedge clk) begin
        if (rst) begin
            ep_pipe <= {EP_WB_DEPTH{1'b0}};
            busy <= 2'h0;
            ep_pending <= 1'b0;
            load_bufs_full <= 1'b0;
        end else begin
            // an ep write stays pending until it has passed writeback
            ep_pipe <= {ep_pipe[EP_WB_DEPTH-2:0], issue_ep_write};
            busy <= next_busy;
            ep_pending <= issue_ep_write || (|ep_pipe[EP_WB_DEPTH-2:0]);
            load_bufs_full <= (next_busy == 2'h2);
        end
    end
endmodule

// [logic/dip_pair_issue.v]
// issue stage that fuses or pairs two consecutive instructions
//
// Contract
// - mov then two-operand op writing same non-r0 register executes as one
// - fusion only when the mov comes first, never reversed
// - unconditional branch pairs with listed flag or simple leading instructions
// - conditional branch pairs only after instructions that leave flags untouched
// - ep relative short load pairs with listed leading alu instructions
// - dual issue only when second is branch, conditional branch or short load
// - no pairing or fusion right after branch to non word aligned target
// - no short load pairing while an ep write awaits writeback
// - no conditional branch pairing if either prior instruction may set flags
// - no short load pairing while both load buffers await writeback
// - hardware breakpoints on paired slots may misfire; debug uses software breaks
`timescale 1ns/1ps
`include "dip_defines.vh"
module dip_pair_issue #(
    parameter EP_WB_DEPTH = 3
) (
    input wire clk,
    input wire rst,
    input wire a_valid,
    input wire [`DIP_CLS_W-1:0] a_cls,
    input wire [`DIP_FMT_W-1:0] a_fmt,
    input wire [`DIP_REG_W-1:0] a_dst,
    input wire a_two_op,
    input wire a_branch_target,
    input wire a_word_aligned,
    input wire b_valid,
    input wire [`DIP_CLS_W-1:0] b_cls,
    input wire [`DIP_FMT_W-1:0] b_fmt,
    input wire [`DIP_REG_W-1:0] b_dst,
    input wire b_two_op,
    input wire load_wb_done,
    input wire hw_break_on,
    output reg issue_valid,
    output reg [`DIP_ISS_W-1:0] issue_kind,
    output reg take_a,
    output reg take_b,
    output reg hw_break_unreliable
);
    wire a_ok_br;
    wire a_ok_bcc;
    wire a_ok_sld;
    wire a_ok_fuse;
    wire a_flags;
    wire b_ok_br;
    wire b_ok_bcc;
    wire b_ok_sld;
    wire b_ok_fuse;
    wire b_flags;
    wire ep_pending;
    wire load_bufs_full;
    reg prev_flags;
    reg issue_ep_write;
    reg load_alloc;
    reg [`DIP_ISS_W-1:0] next_kind;
    reg next_take_b;
    reg fuse_ok;
    reg pair_ok;
    reg blocked;

    function is_short_load;
        input [`DIP_CLS_W-1:0] c;
        begin
            is_short_load = (c == `DIP_C_SLD) || (c == `DIP_C_SLD_EP);
        end
    endfunction

    function is_load;
        input [`DIP_CLS_W-1:0] c;
        begin
            is_load = is_short_load(c) || (c == `DIP_C_OTHER);
        end
    endfunction

    function writes_dst;
        input [`DIP_CLS_W-1:0] c;
        begin
            writes_dst = (c != `DIP_C_NOP) && (c != `DIP_C_CMP) && (c != `DIP_C_TST) && (c != `DIP_C_SST)
                && (c != `DIP_C_BR) && (c != `DIP_C_BCC);
        end
    endfunction

    dip_first_class u_first_a (
        .cls(a_cls),
        .fmt(a_fmt),
        .ok_br(a_ok_br),
        .ok_bcc(a_ok_bcc),
        .ok_sld(a_ok_sld),
        .ok_fuse_op(a_ok_fuse),
        .may_set_flags(a_flags)
    );

    dip_first_class u_first_b (
        .cls(b_cls),
        .fmt(b_fmt),
        .ok_br(b_ok_br),
        .ok_bcc(b_ok_bcc),
        .ok_sld(b_ok_sld),
        .ok_fuse_op(b_ok_fuse),
        .may_set_flags(b_flags)
    );

    dip_hazard_track #(
        .EP_WB_DEPTH(EP_WB_DEPTH)
    ) u_hazard (
        .clk(clk),
        .rst(rst),
        .issue_ep_write(issue_ep_write),
        .load_alloc(load_alloc),
        .load_wb_done(load_wb_done),
        .ep_pending(ep_pending),
        .load_bufs_full(load_bufs_full)
    );

    always @* begin
        // a misaligned branch target restarts fetch on a halfword boundary
        blocked = a_branch_target && !a_word_aligned;
        fuse_ok = 1'b0;
        pair_ok = 1'b0;
        if (a_valid && b_valid && !blocked) begin
            // only mov-first order is fused; op-then-mov falls through
            fuse_ok = (a_cls == `DIP_C_MOV) && b_ok_fuse && b_two_op
                && (a_dst == b_dst) && (a_dst != `DIP_REG_ZERO);
            case (b_cls)
                `DIP_C_BR: begin
                    pair_ok = a_ok_br;
                end
                `DIP_C_BCC: begin
                    // flags from a or the one before it are not ready yet
                    pair_ok = a_ok_bcc && !a_flags && !prev_flags;
                end
                `DIP_C_SLD, `DIP_C_SLD_EP: begin
                    pair_ok = a_ok_sld && !ep_pending && !load_bufs_full
                        && !(a_dst == `DIP_REG_EP && writes_dst(a_cls));
                end
                default: begin
                    pair_ok = 1'b0;
                end
            endcase
        end
        next_take_b = fuse_ok || pair_ok;
        if (!a_valid) begin
            next_kind = `DIP_ISS_NONE;
        end else if (fuse_ok) begin
            next_kind = `DIP_ISS_FUSED;
        end else if (pair_ok) begin
            next_kind = `DIP_ISS_PAIR;
        end else begin
            next_kind = `DIP_ISS_SINGLE;
        end
        // a short load paired into the element pointer is a pending write as well
        issue_ep_write = a_valid && ((a_dst == `DIP_REG_EP && writes_dst(a_cls))
            || (next_take_b && b_dst == `DIP_REG_EP && writes_dst(b_cls)));
        load_alloc = (a_valid && is_load(a_cls)) || (next_take_b && is_load(b_cls));
    end

    always @(posedge clk) begin
        if (rst) begin
            issue_valid <= 1'b0;
            issue_kind <= `DIP_ISS_NONE;
            take_a <= 1'b0;
            take_b <= 1'b0;
            hw_break_unreliable <= 1'b0;
            prev_flags <= 1'b0;
        end else begin
            issue_valid <= a_valid;
            issue_kind <= next_kind;
            take_a <= a_valid;
            take_b <= a_valid && next_take_b;
            // flag a hardware break that lands on a dual-issued slot
            hw_break_unreliable <= hw_break_on && a_valid && next_take_b;
            if (a_valid) begin
                prev_flags <= next_take_b ? b_flags : a_flags;
            end
        end
    end
endmodule

// [verif/dip_fetch_model.sv]
// fetch side model that presents one instruction pair per request
`timescale 1ns/1ps
module dip_fetch_model (
    input wire clk,
    input wire rst,
    input wire go,
    input wire [13:0] nxt_a,
    input wire [12:0] nxt_b,
    output reg vld,
    output reg [13:0] slot_a,
    output reg [12:0] slot_b
);
always @(posedge clk) begin
    vld <= go && !rst;
    // idle slots scramble so a stale pair never looks valid
    slot_a <= go ? nxt_a : ~slot_a;
    slot_b <= go ? nxt_b : ~slot_b;
end
endmodule

// [verif/dip_pair_issue_sva.sv]
// assertions on the pairing issue stage
`timescale 1ns/1ps
`include "dip_defines.vh"
module dip_pair_issue_sva (
    input wire clk,
    input wire rst,
    input wire a_valid,
    input wire [4:0] a_cls,
    input wire [1:0] a_fmt,
    input wire [4:0] a_dst,
    input wire a_branch_target,
    input wire a_word_aligned,
    input wire b_valid,
    input wire [4:0] b_cls,
    input wire [1:0] b_fmt,
    input wire [4:0] b_dst,
    input wire b_two_op,
    input wire issue_valid,
    input wire [1:0] issue_kind,
    input wire take_a,
    input wire take_b,
    input wire hw_break_unreliable
);
default clocking @(posedge clk); endclocking
default disable iff (rst);
wire ok = a_valid && b_valid && !(a_branch_target && !a_word_aligned);
sequence s_ep_wr;
    a_valid && a_dst == `DIP_REG_EP && a_cls == `DIP_C_MOV;
endsequence
sequence s_sld;
    a_valid && b_cls == `DIP_C_SLD_EP;
endsequence
a_take_next: assert property (a_valid |=> issue_valid && take_a) else $error("no issue");
a_idle_quiet: assert property (!a_valid |=> !issue_valid) else $error("idle issue");
a_fuse_mov: assert property (ok && a_cls == `DIP_C_MOV && b_cls == `DIP_C_ARITH && b_fmt == `DIP_F_I
    && b_two_op && a_dst == b_dst && a_dst != 5'h00 |=> issue_kind == `DIP_ISS_FUSED) else $error("no fuse");
a_fuse_imm_add: assert property (ok && a_cls == `DIP_C_MOV && b_cls == `DIP_C_ARITH && b_fmt == `DIP_F_II
    |=> !take_b) else $error("immediate add fused");
a_rev_single: assert property (ok && b_cls == `DIP_C_MOV |=> !take_b) else $error("mov second");
a_misaligned_target: assert property (a_valid && a_branch_target && !a_word_aligned |=> !take_b)
    else $error("misal");
a_kind_take: assert property (issue_valid |-> take_b == issue_kind[1]) else $error("take_b");
a_bcc_flag: assert property (ok && a_cls == `DIP_C_CMP && b_cls == `DIP_C_BCC |=> !take_b) else $error("flag");
a_br_nop: assert property (ok && a_cls == `DIP_C_NOP && a_fmt == `DIP_F_I && b_cls == `DIP_C_BR |=> take_b)
    else $error("br");
a_ep_sld: assert property (s_ep_wr ##1 s_sld |=> !take_b) else $error("ep");
a_hw_dual: assert property (hw_break_unreliable |-> issue_kind[1]) else $error("hw");
endmodule
bind dip_pair_issue dip_pair_issue_sva dip_pair_issue_sva_i (.clk(clk), .rst(rst), .a_valid(a_valid),
    .a_cls(a_cls), .a_fmt(a_fmt), .a_dst(a_dst), .a_branch_target(a_branch_target),
    .a_word_aligned(a_word_aligned), .b_valid(b_valid), .b_cls(b_cls), .b_fmt(b_fmt), .b_dst(b_dst),
    .b_two_op(b_two_op), .issue_valid(issue_valid), .issue_kind(issue_kind), .take_a(take_a),
    .take_b(take_b), .hw_break_unreliable(hw_break_unreliable));

// [verif/tb_dip_pair_issue.sv]
// self-checking bench for the pairing issue stage
`timescale 1ns/1ps
`include "dip_defines.vh"
module tb_dip_pair_issue;
reg clk = 1'b0;
reg rst = 1'b1;
reg go = 1'b0;
reg wb = 1'b0;
reg hw = 1'b0;
reg [1:0] tg = 2'b01;
reg [13:0] na = 14'h0000;
reg [12:0] nb = 13'h0000;
wire vld, iv, ta, tkb, hbu;
wire [13:0] sa;
wire [12:0] sb;
wire [1:0] kind;
integer miscompares = 0;
integer n_checks = 0;
integer i;
always #50 clk = ~clk;
dip_fetch_model dip_fetch_model_i (.clk(clk), .rst(rst), .go(go), .nxt_a(na), .nxt_b(nb), .vld(vld),
    .slot_a(sa), .slot_b(sb));
dip_pair_issue dip_pair_issue_i (.clk(clk), .rst(rst), .a_valid(vld), .a_cls(sa[13:9]), .a_fmt(sa[8:7]),
    .a_dst(sa[6:2]), .a_two_op(1'b0), .a_branch_target(sa[1]), .a_word_aligned(sa[0]), .b_valid(vld),
    .b_cls(sb[12:8]), .b_fmt(sb[7:6]), .b_dst(sb[5:1]), .b_two_op(sb[0]), .load_wb_done(wb),
    .hw_break_on(hw), .issue_valid(iv), .issue_kind(kind), .take_a(ta), .take_b(tkb), .hw_break_unreliable(hbu));
task chk(input [4:0] got, input [4:0] exp);
    begin
        n_checks = n_checks + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    end
endtask
task wrap_up;
    begin
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    end
endtask
// one pair presented for a single cycle, decision read one cycle later
task step_raw(input [13:0] a, input [12:0] b, input [1:0] k);
    begin
        @(posedge clk);
        na <= a;
        nb <= b;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
        chk({iv, ta, tkb, kind}, {2'b11, k[1], k});
    end
endtask
task step(input [4:0] ac, input [4:0] d, input [4:0] bc, input [1:0] k);
    begin
        step_raw({ac, ac == `DIP_C_SHIFT ? `DIP_F_II : (ac >= `DIP_C_SLD ? `DIP_F_IV : `DIP_F_I), d, tg},
            {bc, bc == `DIP_C_SLD_EP ? `DIP_F_IV : `DIP_F_I, d, 1'b1}, k);
    end
endtask
// element pointer write followed in the very next cycle by a short load pair
task t_ep_hold;
    begin
        @(posedge clk);
        na <= {`DIP_C_MOV, `DIP_F_I, `DIP_REG_EP, 2'b01};
        nb <= {`DIP_C_OTHER, `DIP_F_I, 5'h05, 1'b0};
        go <= 1'b1;
        @(posedge clk);
        na <= {`DIP_C_NOP, `DIP_F_I, 5'h00, 2'b01};
        nb <= {`DIP_C_SLD_EP, `DIP_F_IV, 5'h06, 1'b0};
        @(posedge clk);
        go <= 1'b0;
        #1;
        chk({iv, ta, tkb, kind}, {3'b110, `DIP_ISS_SINGLE});
        @(posedge clk);
        #1;
        chk({iv, ta, tkb, kind}, {3'b110, `DIP_ISS_SINGLE});
    end
endtask
task drain;
    begin
        @(posedge clk);
        wb <= 1'b1;
        @(posedge clk);
        wb <= 1'b0;
    end
endtask
task t_fuse;
    reg [13:0] mv;
    begin
        mv = {`DIP_C_MOV, `DIP_F_I, 5'h05, 2'b01};
        step(`DIP_C_MOV, 5'h05, `DIP_C_ARITH, `DIP_ISS_FUSED);
        step_raw(mv, {`DIP_C_SHIFT, `DIP_F_II, 5'h05, 1'b1}, `DIP_ISS_FUSED);
        step_raw(mv, {`DIP_C_ARITH, `DIP_F_II, 5'h05, 1'b1}, `DIP_ISS_SINGLE);
        step_raw(mv, {`DIP_C_ARITH, `DIP_F_I, 5'h05, 1'b0}, `DIP_ISS_SINGLE);
        step(`DIP_C_MOV, 5'h00, `DIP_C_ARITH, `DIP_ISS_SINGLE);
        step(`DIP_C_ARITH, 5'h05, `DIP_C_MOV, `DIP_ISS_SINGLE);
    end
endtask
task t_br;
    begin
        for (i = `DIP_C_NOP; i <= `DIP_C_MULH; i = i + 1) begin
            step(i[4:0], 5'h05, `DIP_C_BR, `DIP_ISS_PAIR);
        end
        step(`DIP_C_SST, 5'h05, `DIP_C_BR, `DIP_ISS_PAIR);
        step(`DIP_C_EXT, 5'h05, `DIP_C_BR, `DIP_ISS_SINGLE);
        @(posedge clk);
        hw <= 1'b1;
        step(`DIP_C_NOP, 5'h00, `DIP_C_BR, `DIP_ISS_PAIR);
        chk({4'h0, hbu}, 5'h01);
        step(`DIP_C_EXT, 5'h05, `DIP_C_BR, `DIP_ISS_SINGLE);
        chk({4'h0, hbu}, 5'h00);
        @(posedge clk);
        hw <= 1'b0;
    end
endtask
task t_bcc;
    begin
        step(`DIP_C_NOP, 5'h00, `DIP_C_OTHER, `DIP_ISS_SINGLE);
        step(`DIP_C_MOV, 5'h05, `DIP_C_BCC, `DIP_ISS_PAIR);
        step(`DIP_C_EXT, 5'h05, `DIP_C_BCC, `DIP_ISS_PAIR);
        step(`DIP_C_ARITH, 5'h05, `DIP_C_BCC, `DIP_ISS_SINGLE);
        step(`DIP_C_NOP, 5'h00, `DIP_C_BCC, `DIP_ISS_SINGLE);
    end
endtask
task t_align;
    begin
        tg = 2'b10;
        step(`DIP_C_NOP, 5'h00, `DIP_C_BR, `DIP_ISS_SINGLE);
        step(`DIP_C_MOV, 5'h05, `DIP_C_ARITH, `DIP_ISS_SINGLE);
        tg = 2'b11;
        step(`DIP_C_NOP, 5'h00, `DIP_C_BR, `DIP_ISS_PAIR);
        tg = 2'b01;
    end
endtask
task t_sld;
    begin
        step(`DIP_C_NOP, 5'h00, `DIP_C_SLD_EP, `DIP_ISS_PAIR);
        step(`DIP_C_MOV, `DIP_REG_EP, `DIP_C_SLD_EP, `DIP_ISS_SINGLE);
        t_ep_hold;
        drain;
        step(`DIP_C_SLD, 5'h07, `DIP_C_OTHER, `DIP_ISS_SINGLE);
        step(`DIP_C_SLD, 5'h08, `DIP_C_OTHER, `DIP_ISS_SINGLE);
        step(`DIP_C_NOP, 5'h00, `DIP_C_SLD_EP, `DIP_ISS_SINGLE);
        drain;
        step(`DIP_C_NOP, 5'h00, `DIP_C_SLD_EP, `DIP_ISS_PAIR);
    end
endtask
initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({iv, ta, tkb, kind}, 5'h00);
    t_fuse;
    t_br;
    t_bcc;
    t_align;
    t_sld;
    wrap_up;
end
initial begin
    repeat (3000) @(posedge clk);
    miscompares = miscompares + 1;
    wrap_up;
end
endmodule
